/* File: design/vsce_pkg.sv */
// package: constants and carrier types for the video memory command engine
package vsce_pkg;
    localparam int ADDR_W = 19;
    // command codes
    localparam logic [7:0] OP_CARET     = 8'h1e;
    localparam logic [7:0] OP_PEN       = 8'h1a;
    localparam logic [7:0] OP_PTRLD0    = 8'h8e;
    localparam logic [7:0] OP_PTRLD1    = 8'h8f;
    localparam logic [7:0] OP_PTRRD     = 8'h8a;
    localparam logic [7:0] OP_MASK      = 8'h89;
    localparam logic [7:0] OP_ABORT     = 8'h88;
    localparam logic [7:0] OP_SPRITE_START_CMD     = 8'h82;
    localparam logic [7:0] OP_SPROFF    = 8'h83;
    localparam logic [7:0] OP_SPRITE_TABLE_READ_CMD     = 8'h80;
    localparam logic [5:0] OP_HRD_HI    = 6'h24;  // 1001_00mm
    localparam logic [5:0] OP_HWR_HI    = 6'h25;  // 1001_01mm
    localparam logic [5:0] OP_DRD_HI    = 6'h26;  // 1001_10mm
    localparam logic [5:0] OP_DWR_HI    = 6'h27;  // 1001_11mm
    // step selections
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_ATR  = 2'h1;
    localparam logic [1:0] STEP_PIT  = 2'h2;
    localparam logic [1:0] STEP_PTR  = 2'h3;
    // resets and limits
    localparam logic [7:0]  MASK_RST   = 8'hff;
    localparam logic [2:0]  ATTR_LAST  = 3'h7;
    localparam logic [1:0]  HI_ZERO3   = 2'h0;
    localparam logic [12:0] SPR_STRIDE = 13'h0008;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_PARAM = 4'h1,
        ST_OUT   = 4'h3,
        ST_RDREQ = 4'h2,
        ST_RDWT  = 4'h6,
        ST_HOLD  = 4'h7,
        ST_WRRD  = 4'h5,
        ST_WRWT  = 4'h4,
        ST_WRDO  = 4'hc,
        ST_ERR   = 4'hd
    } vsce_state_t;

    typedef enum logic [2:0] {
        XF_NONE = 3'h0, XF_HRD = 3'h1, XF_HWR = 3'h2, XF_DRD = 3'h3, XF_DWR = 3'h4, XF_SPR = 3'h5
    } vsce_xfer_t;

    typedef struct packed {
        logic [7:0] limit;     // per_line_sprite_limit
        logic       intEn;     // sprite_interrupt_enable
        logic       dblHeight; // sprite_double_height
        logic       groupCol;  // sprite_group_collide
    } vsce_sprcfg_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } vsce_mem_t;
endpackage : vsce_pkg

/* File: design/vsce_step_unit.sv */
// step unit: next primary pointer from the step selection
`timescale 1ns/1ps
module vsce_step_unit
    import vsce_pkg::*;
(
    input  wire logic [ADDR_W-1:0] ptrIn,    // current primary pointer
    input  wire logic [1:0]        stepSel,  // pointer_step_select
    input  wire logic [ADDR_W-1:0] attribute_offset,   // attribute_offset
    input  wire logic [2:0]        pitch,    // character pitch
    input  wire logic [ADDR_W-1:0] stepPtr,  // step_pointer
    output logic      [ADDR_W-1:0] ptrOut    // stepped pointer
);
    // 19-bit adds drop the carry so the pointer wraps both ways
    always_comb begin
        unique case (stepSel)
            STEP_NONE: ptrOut = ptrIn;
            STEP_ATR:  ptrOut = ptrIn + attribute_offset;
            STEP_PIT:  ptrOut = ptrIn + {{(ADDR_W-3){1'b0}}, pitch};
            STEP_PTR:  ptrOut = ptrIn + stepPtr;
        endcase
    end
endmodule : vsce_step_unit

/* File: design/vsce_engine.sv */
// command engine: pointer, mask, memory streaming, DMA and sprite commands
`timescale 1ns/1ps
module vsce_engine
    import vsce_pkg::*;
(
    input  wire logic              ref_clk,        // 40 MHz clock
    input  wire logic              reset,          // async reset, high
    input  wire logic              cmdValid,       // command byte strobe
    input  wire logic [7:0]        cmdByte,        // command byte
    input  wire logic              parValid,       // parameter/data byte strobe
    input  wire logic [7:0]        parByte,        // parameter/data byte
    input  wire logic              hostTake,       // host took output byte
    output logic                   outValid,       // output byte holds data
    output logic      [7:0]        outByte,        // output byte to host or DMA
    input  wire logic              transfer_ack_n, // DMA acknowledge, low
    input  wire logic              dmaRd,          // DMA read strobe
    input  wire logic              dmaWr,          // DMA write strobe
    output logic                   transfer_request_n, // DMA request, low
    output vsce_mem_t              memOut,         // video memory request
    input  wire logic              memAck,         // memory access done
    input  wire logic [7:0]        memRdata,       // memory read data
    input  wire logic [15:0]       maxLine,        // bottom line of screen
    input  wire logic [15:0]       maxCol,         // right column of screen
    input  wire logic [15:0]       screenBase,     // start address / 256
    input  wire logic [ADDR_W-1:0] attribute_offset,         // attribute_offset
    input  wire logic [2:0]        pitch,          // character pitch
    input  wire logic [15:0]       lineStride,     // bytes per line
    input  wire logic              penHit,         // pen detect pulse
    input  wire logic [15:0]       penLine,        // pen line
    input  wire logic [15:0]       penCol,         // pen column
    input  wire logic              displayOn,      // display enabled
    input  wire logic              spriteEvent,    // collision or over-limit pulse
    input  wire logic              cmdErr,         // command error pulse
    output logic                   penFlag,        // light pen detected
    output logic                   spriteActive,   // sprite display running
    output logic      [15:0]       spriteBase,     // sprite_table_base
    output vsce_sprcfg_t           spriteCfg,      // sprite settings
    output logic                   sprite_event_flag,  // sprite event status
    output logic                   spriteIrq,      // sprite interrupt
    output logic                   command_error_flag, // error status
    output logic      [15:0]       caretLine,      // caret line
    output logic      [15:0]       caretCol        // caret column
);
    typedef struct packed {
        vsce_state_t       st;
        vsce_xfer_t        xf;
        logic [7:0]        op;
        logic [2:0]        pidx;
        logic [31:0]       pbuf;
        logic [ADDR_W-1:0] ptr0, ptr1;
        logic [7:0]        mask, wbyte, obyte;
        logic              oval;
        logic [1:0]        stepSel;
        logic [4:0]        sprNum;
        logic [2:0]        attrIdx;
        vsce_mem_t         mem;
        logic              dreq, reqN, pen, sact, sevt, irq, err;
        vsce_sprcfg_t      scfg;
        logic [15:0]       sbase, cLine, cCol;
    } vsce_regs_t;

    vsce_regs_t q, d;
    logic [ADDR_W-1:0] stepped;
    logic [ADDR_W-1:0] coordAddr;
    logic [15:0]       useLine, useCol;
    logic              isCoordCmd;

    // pointer stepping lives in its own unit
    vsce_step_unit u_step (
        .ptrIn  (q.ptr0),
        .stepSel(q.stepSel),
        .attribute_offset (attribute_offset),
        .pitch  (pitch),
        .stepPtr(q.ptr1),
        .ptrOut (stepped)
    );

    // coordinate to address; shared by caret and pen commands
    always_comb begin
        logic [15:0] cl, cc;
        cl = q.pbuf[15:0] > maxLine ? maxLine : q.pbuf[15:0];
        cc = q.pbuf[31:16] > maxCol ? maxCol : q.pbuf[31:16];
        // pen coordinates only while the pen command is being taken
        isCoordCmd = !(cmdValid && cmdByte == OP_PEN);
        useLine = isCoordCmd ? cl : penLine;
        useCol  = isCoordCmd ? cc : penCol;
        coordAddr = ADDR_W'({screenBase, 8'h00} + useLine * lineStride + {3'h0, useCol});
    end

    function automatic logic [2:0] param_count(input logic [7:0] op);
        param_count = 3'h0;
        if (op == OP_CARET) param_count = 3'h4;
        if (op == OP_PTRLD0 || op == OP_PTRLD1 || op == OP_SPRITE_START_CMD) param_count = 3'h3;
        if (op == OP_MASK) param_count = 3'h1;
        if (op == OP_SPRITE_TABLE_READ_CMD) param_count = 3'h1;
    endfunction : param_count

    // next-state logic for all engine state
    always_comb begin
        d = q;
        d.irq = q.scfg.intEn && q.sevt && q.sact;
        if (!transfer_ack_n && dmaRd && q.xf == XF_DRD) begin
            d.oval = 1'b0;
            d.dreq = 1'b0;
        end
        if (hostTake && q.xf != XF_DRD) d.oval = 1'b0;
        unique case (q.st)
            ST_IDLE, ST_PARAM, ST_HOLD, ST_ERR, ST_OUT: ;
            ST_RDREQ: begin
                d.mem.req = 1'b1;
                d.mem.we  = 1'b0;
                d.mem.addr = q.ptr0;
                d.st = ST_RDWT;
            end
            ST_RDWT: if (memAck) begin
                d.mem.req = 1'b0;
                d.obyte = memRdata;
                d.oval = 1'b1;
                if (q.xf == XF_DRD) d.dreq = 1'b1;
                d.st = ST_HOLD;
            end
            ST_WRRD: begin
                d.mem.req = 1'b1;
                d.mem.we = 1'b0;
                d.mem.addr = q.ptr0;
                d.st = ST_WRWT;
            end
            ST_WRWT: if (memAck) begin
                d.mem.we = 1'b1;
                d.mem.wdata = (memRdata & ~q.mask) | (q.wbyte & q.mask);
                d.st = ST_WRDO;
            end
            ST_WRDO: if (memAck) begin
                d.mem.req = 1'b0;
                d.mem.we = 1'b0;
                d.ptr0 = stepped;
                d.dreq = (q.xf == XF_DWR);
                d.st = ST_HOLD;
            end
            default: d.st = ST_IDLE;
        endcase
        // streaming: consume or refill in the hold state
        if (q.st == ST_HOLD && !cmdErr) begin
            if ((q.xf == XF_HRD || q.xf == XF_DRD) && !q.oval) begin
                d.ptr0 = stepped;
                d.st = ST_RDREQ;
            end else if (q.xf == XF_SPR && !q.oval) begin
                d.attrIdx = q.attrIdx + 3'h1;
                if (q.attrIdx == ATTR_LAST) d.sprNum = q.sprNum + 5'h1;
                d.ptr0 = ADDR_W'({q.sbase, 8'h00} + d.sprNum * SPR_STRIDE + d.attrIdx);
                d.st = ST_RDREQ;
            end else if (q.xf == XF_HWR && parValid) begin
                d.wbyte = parByte;
                d.st = ST_WRRD;
            end else if (q.xf == XF_DWR && !transfer_ack_n && dmaWr) begin
                d.wbyte = parByte;
                d.dreq = 1'b0;
                d.st = ST_WRRD;
            end
        end
        // parameter collection
        if (q.st == ST_PARAM && parValid) begin
            d.pbuf[8*q.pidx[1:0] +: 8] = parByte;
            d.pidx = q.pidx + 3'h1;
            if (q.pidx + 3'h1 == param_count(q.op)) d.st = ST_OUT;
        end
        // execute after last parameter; readouts share the state but run below
        if (q.st == ST_OUT && !cmdErr && q.op != OP_PEN && q.op != OP_PTRRD) begin
            d.st = ST_IDLE;
            if (q.op == OP_CARET) begin
                d.cLine = useLine;
                d.cCol = useCol;
                d.ptr0 = coordAddr;
            end else if (q.op == OP_PTRLD0) begin
                d.ptr0 = q.pbuf[ADDR_W-1:0];
            end else if (q.op == OP_PTRLD1) begin
                d.ptr1 = q.pbuf[ADDR_W-1:0];
            end else if (q.op == OP_MASK) begin
                d.mask = q.pbuf[7:0];
            end else if (q.op == OP_SPRITE_START_CMD) begin
                d.sbase = q.pbuf[15:0];
                d.scfg = {HI_ZERO3, 1'b0, q.pbuf[23:19], q.pbuf[18:16]};
                d.sact = displayOn;
                d.sevt = 1'b0;
            end else if (q.op == OP_SPRITE_TABLE_READ_CMD) begin
                d.sprNum = q.pbuf[7:3];
                d.attrIdx = q.pbuf[2:0];
                d.ptr0 = ADDR_W'({q.sbase, 8'h00} + {q.pbuf[7:0]});
                d.xf = XF_SPR;
                d.st = ST_RDREQ;
            end
        end
        // new command byte
        if (cmdValid) begin
            d.oval = 1'b0;
            d.dreq = 1'b0;
            d.mem.req = 1'b0;
            d.mem.we = 1'b0;
            d.xf = XF_NONE;
            d.op = cmdByte;
            d.pidx = 3'h0;
            d.pbuf = 32'h0;
            d.st = ST_IDLE;
            if (cmdByte == OP_ABORT) begin
                d.err = 1'b0;
            end else if (q.st == ST_ERR) begin
                d.st = ST_ERR;
                d.op = q.op;
            end else if (param_count(cmdByte) != 3'h0) begin
                d.st = ST_PARAM;
            end else if (cmdByte == OP_PEN) begin
                d.ptr0 = coordAddr;
                d.pen = 1'b0;
                d.obyte = penLine[7:0];
                d.oval = 1'b1;
                d.st = ST_OUT;
                d.pidx = 3'h1;
            end else if (cmdByte == OP_PTRRD) begin
                d.obyte = d.ptr0[7:0];
                d.oval = 1'b1;
                d.st = ST_OUT;
                d.pidx = 3'h1;
            end else if (cmdByte == OP_SPROFF) begin
                d.sact = 1'b0;
            end else if (cmdByte[7:2] == OP_HRD_HI || cmdByte[7:2] == OP_DRD_HI) begin
                d.stepSel = cmdByte[1:0];
                d.xf = cmdByte[3] ? XF_DRD : XF_HRD;
                d.st = ST_RDREQ;
            end else if (cmdByte[7:2] == OP_HWR_HI || cmdByte[7:2] == OP_DWR_HI) begin
                d.stepSel = cmdByte[1:0];
                d.xf = cmdByte[3] ? XF_DWR : XF_HWR;
                d.dreq = cmdByte[3];
                d.st = ST_HOLD;
            end
        end
        // multi-byte readouts: pen and pointer; any new command byte, abort included, stops them
        if (!cmdValid && q.st == ST_OUT && (q.op == OP_PEN || q.op == OP_PTRRD) && hostTake) begin
            d.pidx = q.pidx + 3'h1;
            d.oval = q.pidx != 3'h4 && !(q.op == OP_PTRRD && q.pidx == 3'h3);
            d.st = d.oval ? ST_OUT : ST_IDLE;
            if (q.op == OP_PTRRD) begin
                d.obyte = q.pidx == 3'h1 ? q.ptr0[15:8] : {5'h0, q.ptr0[18:16]};
            end else begin
                unique case (q.pidx)
                    3'h1: d.obyte = penLine[15:8];
                    3'h2: d.obyte = penCol[7:0];
                    default: d.obyte = penCol[15:8];
                endcase
            end
        end
        // sets come last so an event beats a clear in the same cycle
        if (penHit) d.pen = 1'b1;
        if (spriteEvent && q.sact) d.sevt = 1'b1;
        if (cmdErr) begin
            d.err = 1'b1;
            d.st  = ST_ERR;
        end
        d.reqN = ~d.dreq;
    end

    // single register stage for the whole engine
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.mask <= MASK_RST;
            q.reqN <= 1'b1;
            q.st <= ST_IDLE;
            q.xf <= XF_NONE;
        end else begin
            q <= d;
        end
    end

    assign outValid = q.oval;
    assign outByte = q.obyte;
    assign transfer_request_n = q.reqN;
    assign memOut = q.mem;
    assign penFlag = q.pen;
    assign spriteActive = q.sact;
    assign spriteBase = q.sbase;
    assign spriteCfg = q.scfg;
    assign sprite_event_flag = q.sevt;
    assign spriteIrq = q.irq;
    assign command_error_flag = q.err;
    assign caretLine = q.cLine;
    assign caretCol = q.cCol;
endmodule : vsce_engine

/* File: verification/vsce_engine_checker.sv */
// checker: port-level assertions for the video memory command engine
`timescale 1ns/1ps
module vsce_engine_checker
    import vsce_pkg::*;
(
    input wire logic         ref_clk,            // clock
    input wire logic         reset,              // async reset
    input wire logic         cmdValid,           // command strobe
    input wire logic [7:0]   cmdByte,            // command byte
    input wire logic         parValid,           // parameter strobe
    input wire logic [7:0]   parByte,            // parameter byte
    input wire logic         dmaWr,              // DMA write strobe
    input wire logic         transfer_ack_n,     // DMA acknowledge
    input wire logic         outValid,           // output byte held
    input wire logic [7:0]   outByte,            // output byte
    input wire logic         transfer_request_n, // DMA request
    input wire vsce_mem_t    memOut,             // memory request
    input wire logic         memAck,             // memory done
    input wire logic [7:0]   memRdata,           // memory data
    input wire logic [15:0]  maxLine,            // bottom line
    input wire logic [15:0]  maxCol,             // right column
    input wire logic [15:0]  caretLine,          // caret line
    input wire logic [15:0]  caretCol,           // caret column
    input wire logic         penHit,             // pen pulse
    input wire logic         penFlag,            // pen status
    input wire vsce_sprcfg_t spriteCfg,          // sprite settings
    input wire logic         spriteIrq,          // sprite interrupt
    input wire logic         spriteActive,       // sprite display
    input wire logic         command_error_flag  // error status
);
    logic [7:0] lastCmd_q, mask_q, old_q, new_q;
    // shadows of the mask and of both merge operands; mask is taken from every parameter byte while the last command is the mask command
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lastCmd_q <= 8'h00;
            mask_q    <= MASK_RST;
            old_q     <= 8'h00;
            new_q     <= 8'h00;
        end else begin
            if (cmdValid) lastCmd_q <= cmdByte;
            if (parValid && lastCmd_q == OP_MASK) mask_q <= parByte;
            if (parValid || (dmaWr && !transfer_ack_n)) new_q <= parByte;
            if (memAck && !memOut.we) old_q <= memRdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_abort;
        cmdValid && cmdByte == OP_ABORT;
    endsequence
    sequence s_hread;
        lastCmd_q[7:2] == OP_HRD_HI && memAck && !memOut.we;
    endsequence
    a_read_byte_out: assert property (s_hread |=> outValid && outByte == $past(memRdata))
        else $error("host read byte differs from memory");
    a_write_merge_ok: assert property (memOut.req && memOut.we |-> memOut.wdata == ((old_q & ~mask_q) | (new_q & mask_q)))
        else $error("masked write data wrong");
    a_abort_clears_err: assert property (s_abort |-> ##[1:4] !command_error_flag)
        else $error("error flag kept after abort");
    a_error_holds: assert property (command_error_flag && !(cmdValid && cmdByte == OP_ABORT) |=> command_error_flag)
        else $error("error flag dropped without abort");
    a_abort_drops_req: assert property (s_abort |-> ##[1:3] transfer_request_n)
        else $error("DMA request kept after abort");
    a_caret_clamped: assert property (caretLine <= maxLine && caretCol <= maxCol)
        else $error("caret beyond screen edge");
    a_pen_sets_flag: assert property (penHit |=> penFlag)
        else $error("pen flag not set");
    a_irq_needs_en: assert property ($rose(spriteIrq) |-> spriteCfg.intEn)
        else $error("sprite interrupt while disabled");
    a_stop_ends_sprite: assert property (cmdValid && cmdByte == OP_SPROFF && !command_error_flag |-> ##[1:4] !spriteActive)
        else $error("sprite display kept after stop");
endmodule : vsce_engine_checker

bind vsce_engine vsce_engine_checker u_chk (.*);

/* File: verification/vsce_mem_model.sv */
// video memory model: answers one access at a time, fast on even and slow on odd addresses
`timescale 1ns/1ps
module vsce_mem_model
    import vsce_pkg::*;
(
    input wire logic      ref_clk,  // clock
    input wire logic      reset,    // async reset
    input wire vsce_mem_t memIn,    // access request
    output logic          memAck,   // access done pulse
    output logic [7:0]    memRdata  // read data with ack
);
    logic [7:0] store [int];
    int         waitCnt;
    // unwritten bytes read as low address byte xor middle byte; data toggles outside answers so no stale value
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            memAck   <= 1'b0;
            waitCnt  <= 0;
            memRdata <= 8'h00;
        end else begin
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
            if (memIn.req && !memAck) begin
                if (waitCnt < (memIn.addr[0] ? 3 : 0)) waitCnt <= waitCnt + 1;
                else begin
                    waitCnt <= 0;
                    memAck  <= 1'b1;
                    if (memIn.we) store[int'(memIn.addr)] = memIn.wdata;
                    else if (store.exists(int'(memIn.addr))) memRdata <= store[int'(memIn.addr)];
                    else memRdata <= memIn.addr[7:0] ^ memIn.addr[15:8];
                end
            end
        end
    end
endmodule : vsce_mem_model

/* File: verification/vsce_engine_test.sv */
// testbench: command sequences against the video memory command engine
`timescale 1ns/1ps
module vsce_engine_test
    import vsce_pkg::*;
();
    logic              ref_clk = 1'b0, reset = 1'b1, cmdValid = 1'b0, parValid = 1'b0, hostTake = 1'b0;
    logic              transfer_ack_n = 1'b1, dmaRd = 1'b0, dmaWr = 1'b0, penHit = 1'b0, cmdErr = 1'b0;
    logic              displayOn = 1'b0, spriteEvent = 1'b0, memAck, outValid, transfer_request_n;
    logic [7:0]        cmdByte = 8'h00, parByte = 8'h00, memRdata, outByte;
    logic [15:0]       maxLine = 16'h0018, maxCol = 16'h0100, screenBase = 16'h0010, lineStride = 16'h0050;
    logic [15:0]       penLine = 16'h0000, penCol = 16'h0000, spriteBase, caretLine, caretCol;
    logic [ADDR_W-1:0] attribute_offset = 19'h00100;
    logic [ADDR_W-1:0] inc [4];
    logic [2:0]        pitch = 3'h2;
    logic              penFlag, spriteActive, sprite_event_flag, spriteIrq, command_error_flag;
    vsce_mem_t         memOut;
    vsce_sprcfg_t      spriteCfg;
    int                err_total = 0, checks = 0;
    vsce_engine dut (.*);
    vsce_mem_model mem (.ref_clk(ref_clk), .reset(reset), .memIn(memOut), .memAck(memAck), .memRdata(memRdata));
    // 40 MHz
    always #12.5 ref_clk = ~ref_clk;
    function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[15:8];
    endfunction : pat
    task automatic tick();
        @(posedge ref_clk);
        #2;
    endtask : tick
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    // bounded wait: 0 output byte, 1 DMA request, 2 memory write done; running out ends the run
    task automatic await(input int k);
        for (int i = 0; i < 300; i++) begin
            if ((k == 0 ? outValid : k == 1 ? !transfer_request_n : memOut.req && memOut.we && memAck) === 1'b1) return;
            tick();
        end
        err_total++;
        complete_run();
    endtask : await
    task automatic cmd(input logic [7:0] b);
        cmdByte  = b;
        cmdValid = 1'b1;
        tick();
        cmdValid = 1'b0;
    endtask : cmd
    task automatic par(input logic [7:0] b);
        parByte  = b;
        parValid = 1'b1;
        tick();
        parValid = 1'b0;
    endtask : par
    task automatic get(input logic [7:0] exp);
        await(0);
        chk("outByte", outByte, exp);
        hostTake = 1'b1;
        tick();
        hostTake = 1'b0;
    endtask : get
    task automatic ld(input logic n, input logic [ADDR_W-1:0] a);
        cmd(n ? OP_PTRLD1 : OP_PTRLD0);
        par(a[7:0]);
        par(a[15:8]);
        par({5'h00, a[18:16]});
    endtask : ld
    task automatic rb(input logic [ADDR_W-1:0] a);
        cmd(OP_PTRRD);
        get(a[7:0]);
        get(a[15:8]);
        get({5'h00, a[18:16]});
    endtask : rb
    // one write byte by host strobe or by DMA strobe, then wait for its memory write
    task automatic put(input logic dma, input logic [7:0] b);
        if (dma) await(1);
        {transfer_ack_n, dmaWr, parValid} = dma ? 3'b010 : 3'b101;
        parByte = b;
        tick();
        {transfer_ack_n, dmaWr, parValid} = 3'b100;
        await(2);
        tick();
    endtask : put
    // DMA read of one byte with the controller stalling two cycles first
    task automatic dget(input logic [7:0] exp);
        await(1);
        repeat (2) tick();
        chk("transfer_request_n", transfer_request_n, 1'b0);
        chk("outByte", outByte, exp);
        {transfer_ack_n, dmaRd} = 2'b01;
        tick();
        {transfer_ack_n, dmaRd} = 2'b10;
    endtask : dget
    // reads two masked bytes back, mask 0f, old data from the memory pattern
    task automatic vrf(input logic [ADDR_W-1:0] a, input logic [7:0] b0, input logic [7:0] b1);
        ld(1'b0, a);
        cmd({OP_HRD_HI, STEP_ATR});
        get((pat(a) & 8'hf0) | (b0 & 8'h0f));
        get((pat(a + attribute_offset) & 8'hf0) | (b1 & 8'h0f));
    endtask : vrf
    task automatic caret(input logic [15:0] l, input logic [15:0] c, input logic [15:0] el, input logic [15:0] ec);
        cmd(OP_CARET);
        par(l[7:0]);
        par(l[15:8]);
        par(c[7:0]);
        par(c[15:8]);
        repeat (2) tick();
        chk("caretLine", caretLine, el);
        chk("caretCol", caretCol, ec);
    endtask : caret
    task automatic spr(input logic [7:0] f);
        cmd(OP_SPRITE_START_CMD);
        par(8'h12);
        par(8'h00);
        par(f);
        repeat (2) tick();
    endtask : spr
    // main sequence
    initial begin
        inc = '{19'h00000, attribute_offset, {16'h0000, pitch}, 19'h00003};
        repeat (6) tick();
        reset = 1'b0;
        ld(1'b0, 19'h7fffe);
        rb(19'h7fffe);
        ld(1'b1, 19'h00003);
        for (int m = 0; m < 4; m++) begin
            ld(1'b0, 19'h00100);
            cmd({OP_HRD_HI, m[1:0]});
            get(pat(19'h00100));
            get(pat(19'h00100 + inc[m]));
        end
        ld(1'b0, 19'h7ffff);
        cmd({OP_HRD_HI, STEP_PTR});
        get(pat(19'h7ffff));
        get(pat(19'h00002));
        rb(19'h00005);
        cmd(OP_MASK);
        par(8'h0f);
        ld(1'b0, 19'h00200);
        cmd({OP_HWR_HI, STEP_ATR});
        put(1'b0, 8'ha5);
        put(1'b0, 8'h3c);
        vrf(19'h00200, 8'ha5, 8'h3c);
        ld(1'b0, 19'h00500);
        cmd({OP_DWR_HI, STEP_ATR});
        put(1'b1, 8'h96);
        put(1'b1, 8'h69);
        vrf(19'h00500, 8'h96, 8'h69);
        ld(1'b0, 19'h00040);
        cmd({OP_DRD_HI, STEP_PIT});
        for (int i = 0; i < 3; i++) dget(pat(19'h00040 + ADDR_W'(2 * i)));
        await(1);
        rb(19'h00046);
        chk("transfer_request_n", transfer_request_n, 1'b1);
        cmd(OP_PTRLD0);
        par(8'h55);
        cmd(OP_ABORT);
        rb(19'h00046);
        chk("command_error_flag", command_error_flag, 1'b0);
        cmdErr = 1'b1;
        tick();
        cmdErr = 1'b0;
        cmd(OP_PTRRD);
        repeat (4) tick();
        chk("command_error_flag", command_error_flag, 1'b1);
        chk("outValid", outValid, 1'b0);
        cmd(OP_ABORT);
        tick();
        chk("command_error_flag", command_error_flag, 1'b0);
        caret(16'h0003, 16'h0007, 16'h0003, 16'h0007);
        maxCol = 16'h004f;
        caret(16'h0128, 16'h00c8, 16'h0018, 16'h004f);
        rb(19'h017cf);
        {penCol, penLine} = 32'h0209_0105;
        penHit = 1'b1;
        tick();
        penHit = 1'b0;
        tick();
        chk("penFlag", penFlag, 1'b1);
        cmd(OP_PEN);
        for (int i = 0; i < 4; i++) get(8'(({penCol, penLine}) >> (8 * i)));
        chk("penFlag", penFlag, 1'b0);
        rb(19'h06399);
        spr(8'hf5);
        chk("spriteActive", spriteActive, 1'b0);
        chk("spriteBase", spriteBase, 16'h0012);
        chk("spriteCfg", spriteCfg, {8'h1e, 3'b101});
        displayOn = 1'b1;
        spr(8'hf5);
        chk("spriteActive", spriteActive, 1'b1);
        cmd(OP_ABORT);
        tick();
        chk("spriteActive", spriteActive, 1'b1);
        spriteEvent = 1'b1;
        tick();
        spriteEvent = 1'b0;
        tick();
        chk("sprite_event_flag", sprite_event_flag, 1'b1);
        chk("spriteIrq", spriteIrq, 1'b1);
        spr(8'hf2);
        chk("sprite_event_flag", sprite_event_flag, 1'b0);
        chk("spriteCfg", spriteCfg, {8'h1e, 3'b010});
        cmd(OP_SPRITE_TABLE_READ_CMD);
        par(8'h16);
        get(8'h04);
        get(8'h05);
        get(8'h0a);
        cmd(OP_SPROFF);
        repeat (3) tick();
        chk("spriteActive", spriteActive, 1'b0);
        complete_run();
    end
endmodule : vsce_engine_test
